//--- gpio_port_pkg.sv
package gpio_port_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int PORT_WIDTH = 16;
    localparam int ADDR_WIDTH = 8;

    // ------------------------------------------------------------
    // register offsets (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_PIN_DIRECTION  = 8'h00;
    localparam logic [7:0] OFS_PIN_LEVEL      = 8'h04;
    localparam logic [7:0] OFS_OUTPUT_LATCH   = 8'h08;
    localparam logic [7:0] OFS_OPEN_DRAIN_SEL = 8'h0c;
    localparam logic [7:0] OFS_ANALOG_SEL     = 8'h10;

    // ------------------------------------------------------------
    // reset values, before the implemented-bit mask is applied
    // ------------------------------------------------------------
    localparam logic [15:0] RST_PIN_DIRECTION  = 16'hffff;
    localparam logic [15:0] RST_OUTPUT_LATCH   = 16'h0000;
    localparam logic [15:0] RST_OPEN_DRAIN_SEL = 16'h0000;
    localparam logic [15:0] RST_ANALOG_SEL     = 16'hffff;
    localparam logic [15:0] ALL_ZERO           = 16'h0000;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic [15:0] enable;
        logic [15:0] drive;
        logic [15:0] data;
    } periph_out_t;

    typedef struct packed {
        logic [15:0] pin_direction_reg;
        logic [15:0] output_latch_reg;
        logic [15:0] open_drain_select_reg;
        logic [15:0] analog_select_reg;
        logic [15:0] pad_meta;
        logic [15:0] pad_sync;
        logic [15:0] rdata;
        logic [15:0] pad_out;
        logic [15:0] pad_oe;
        logic [15:0] periph_in;
    } port_state_t;

endpackage

//--- shared_parallel_io_port.sv
`timescale 1ns/100ps
// Operation
// RULE1: a pin whose peripheral is enabled and driving takes data and drive from it, still readable.
// RULE2: an enabled peripheral that is not driving a pin leaves that pin to latch and direction.
// RULE3: the port's own driven value never reaches the peripheral input of the same pin.
// RULE4: a direction bit of one makes the pin an input with its driver off, zero an output.
// RULE5: after any reset every pin is an input with all direction bits set.
// RULE6: reading the latch register gives the latch, writing it loads the latch.
// RULE7: reading the pin-level register gives sampled pins, writing it loads the latch.
// RULE8: unimplemented bits are disabled and read zero in latch, direction and pin level.
// RULE9: port C bits 13 and 14 are inputs only and never drive.
// RULE10: software leaves one instruction cycle between a direction or port write and a read.
// RULE11: an open-drain bit set makes the pin drive low only and float high.
// RULE12: each pin with an analog function has one analog-select bit working with its direction.
// RULE13: pins in analog mode read zero in the pin-level register.
// RULE14: analog-select one means analog with digital read off, zero digital; resets to one.
// RULE15: all port registers are 16 bits, bit n serving pin n.
module shared_parallel_io_port #(
    parameter logic [15:0] IMPL_MASK       = 16'hffff,
    parameter logic [15:0] ANALOG_MASK     = 16'hffff,
    parameter logic [15:0] INPUT_ONLY_MASK = 16'h6000
) (
    input  wire logic                        mclk,
    input  wire logic                        resetn,
    input  wire gpio_port_pkg::reg_req_t     bus_req,
    output logic [15:0]                      bus_rdata,
    input  wire logic [15:0]                 pad_in,
    output logic [15:0]                      pad_out,
    output logic [15:0]                      pad_oe,
    input  wire gpio_port_pkg::periph_out_t  periph,
    output logic [15:0]                      periph_in,
    output logic [15:0]                      analog_mode
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    gpio_port_pkg::port_state_t st_ff;   // sixteen bits per register, bit n for pin n [RULE15]
    gpio_port_pkg::port_state_t nxt_st;

    logic [15:0] own_c;
    logic [15:0] port_drv_c;
    logic [15:0] drv_data_c;
    logic [15:0] drive_c;
    logic [15:0] level_c;

    // analog-capable bits only; the rest of the analog register is absent
    localparam logic [15:0] ANS_BITS = ANALOG_MASK & IMPL_MASK;
    // pins that may ever drive the pad
    localparam logic [15:0] DRIVE_OK = IMPL_MASK & ~INPUT_ONLY_MASK;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // one address comparison used by the write decode; reads decode with a case
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    // ------------------------------------------------------------
    // pin ownership and drive
    // ------------------------------------------------------------
    // the peripheral wins a pin only while both enabled and driving it
    assign own_c      = periph.enable & periph.drive;                       // [RULE1]
    // port drives where it owns the pin and direction is output; input-only
    // and missing pins never drive, so input-only pins keep their peripheral input open
    assign port_drv_c = ~own_c & ~st_ff.pin_direction_reg & DRIVE_OK;       // [RULE2] [RULE4]
    assign drv_data_c = (own_c & periph.data) | (~own_c & st_ff.output_latch_reg);
    // input-only and missing pins are removed from every drive path
    assign drive_c    = (own_c | port_drv_c) & DRIVE_OK;                    // [RULE9] [RULE8]
    // analog pins lose their digital read path
    assign level_c    = st_ff.pad_sync & ~st_ff.analog_select_reg & IMPL_MASK; // [RULE13] [RULE14]

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        // two-stage sampler; the first stage feeds only the second
        nxt_st.pad_meta = pad_in;
        nxt_st.pad_sync = st_ff.pad_meta;

        // register writes, masked to the implemented bits
        if (bus_req.wr) begin
            if (hit(bus_req.addr, gpio_port_pkg::OFS_PIN_DIRECTION)) begin
                nxt_st.pin_direction_reg = bus_req.wdata & IMPL_MASK;       // [RULE4] [RULE8]
            end
            if (hit(bus_req.addr, gpio_port_pkg::OFS_OUTPUT_LATCH)) begin
                nxt_st.output_latch_reg = bus_req.wdata & IMPL_MASK;        // [RULE6]
            end
            if (hit(bus_req.addr, gpio_port_pkg::OFS_PIN_LEVEL)) begin
                // writes through the level register land in the latch
                nxt_st.output_latch_reg = bus_req.wdata & IMPL_MASK;        // [RULE7]
            end
            if (hit(bus_req.addr, gpio_port_pkg::OFS_OPEN_DRAIN_SEL)) begin
                nxt_st.open_drain_select_reg = bus_req.wdata & IMPL_MASK;   // [RULE11]
            end
            if (hit(bus_req.addr, gpio_port_pkg::OFS_ANALOG_SEL)) begin
                nxt_st.analog_select_reg = bus_req.wdata & ANS_BITS;        // [RULE12]
            end
        end

        // read data stands for one cycle only, zero otherwise
        nxt_st.rdata = gpio_port_pkg::ALL_ZERO;
        if (bus_req.rd) begin
            case (bus_req.addr)
                gpio_port_pkg::OFS_PIN_DIRECTION:  nxt_st.rdata = st_ff.pin_direction_reg;
                gpio_port_pkg::OFS_OUTPUT_LATCH:   nxt_st.rdata = st_ff.output_latch_reg; // [RULE6]
                gpio_port_pkg::OFS_PIN_LEVEL:      nxt_st.rdata = level_c;   // [RULE7]
                gpio_port_pkg::OFS_OPEN_DRAIN_SEL: nxt_st.rdata = st_ff.open_drain_select_reg;
                gpio_port_pkg::OFS_ANALOG_SEL:     nxt_st.rdata = st_ff.analog_select_reg;
                default:                           nxt_st.rdata = gpio_port_pkg::ALL_ZERO;
            endcase
        end

        // pad drive: open-drain pins drive only a low level
        nxt_st.pad_out = drv_data_c & ~st_ff.open_drain_select_reg & DRIVE_OK; // [RULE11]
        nxt_st.pad_oe  = drive_c & (~st_ff.open_drain_select_reg | ~drv_data_c); // [RULE11]

        // peripheral sees each implemented digital pin except where the port itself drives it
        nxt_st.periph_in = st_ff.pad_sync & ~port_drv_c                     // [RULE3]
                           & ~st_ff.analog_select_reg & IMPL_MASK;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // sampler latency of two cycles is covered by the software gap
    // between a port write and a read of the same port [RULE10]
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st_ff.pin_direction_reg     <= gpio_port_pkg::RST_PIN_DIRECTION & IMPL_MASK; // [RULE5]
            st_ff.output_latch_reg      <= gpio_port_pkg::RST_OUTPUT_LATCH;
            st_ff.open_drain_select_reg <= gpio_port_pkg::RST_OPEN_DRAIN_SEL;
            st_ff.analog_select_reg     <= gpio_port_pkg::RST_ANALOG_SEL & ANS_BITS;    // [RULE14]
            st_ff.pad_meta              <= gpio_port_pkg::ALL_ZERO;
            st_ff.pad_sync              <= gpio_port_pkg::ALL_ZERO;
            st_ff.rdata                 <= gpio_port_pkg::ALL_ZERO;
            st_ff.pad_out               <= gpio_port_pkg::ALL_ZERO;
            st_ff.pad_oe                <= gpio_port_pkg::ALL_ZERO;
            st_ff.periph_in             <= gpio_port_pkg::ALL_ZERO;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bus_rdata   = st_ff.rdata;
    assign pad_out     = st_ff.pad_out;
    assign pad_oe      = st_ff.pad_oe;
    assign periph_in   = st_ff.periph_in;
    assign analog_mode = st_ff.analog_select_reg;                           // [RULE12]

    // ------------------------------------------------------------
    // assertions: reset
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // the first edge after release still shows what reset left behind
    a_reset_all_inputs: assert property ( // [RULE5]
        !$past(resetn) |-> (st_ff.pin_direction_reg == IMPL_MASK && pad_oe == 16'h0000))
        else $error("pins not inputs after reset");

    a_reset_outputs_low: assert property ( // [RULE5]
        !$past(resetn) |-> (pad_out == 16'h0000 && periph_in == 16'h0000
                            && bus_rdata == 16'h0000))
        else $error("outputs not cleared after reset");

    a_analog_reset_one: assert property ( // [RULE14]
        !$past(resetn) |-> (st_ff.analog_select_reg == ANS_BITS))
        else $error("analog select not set after reset");

    // ------------------------------------------------------------
    // assertions: pin ownership and drive
    // ------------------------------------------------------------
    // pad outputs are registered, so each check with a cause looks one edge after it; the mask checks hold on every edge
    a_input_driver_off: assert property ( // [RULE4]
        1'b1 |=> ((pad_oe & ~$past(own_c) & $past(st_ff.pin_direction_reg)) == 16'h0000))
        else $error("input pin driven by port");

    a_periph_owns_pin: assert property ( // [RULE1]
        1'b1 |=> (((pad_out ^ ($past(periph.data) & ~$past(st_ff.open_drain_select_reg)))
                   & $past(own_c) & DRIVE_OK) == 16'h0000))
        else $error("peripheral data not on owned pin");

    a_owned_pin_drives: assert property ( // [RULE1]
        1'b1 |=> ((~pad_oe & $past(own_c) & ~$past(st_ff.open_drain_select_reg)
                   & DRIVE_OK) == 16'h0000))
        else $error("owned pin driver off");

    a_port_keeps_pin: assert property ( // [RULE2]
        1'b1 |=> (((pad_out ^ ($past(st_ff.output_latch_reg)
                               & ~$past(st_ff.open_drain_select_reg)))
                   & ~$past(own_c) & DRIVE_OK) == 16'h0000))
        else $error("latch not on port owned pin");

    a_idle_periph_port: assert property ( // [RULE2]
        1'b1 |=> (((pad_oe ^ ~$past(st_ff.pin_direction_reg))
                   & $past(periph.enable) & ~$past(periph.drive)
                   & ~$past(st_ff.open_drain_select_reg) & DRIVE_OK) == 16'h0000))
        else $error("idle peripheral blocked port drive");

    a_no_loop_through: assert property ( // [RULE3]
        1'b1 |=> ((periph_in & $past(port_drv_c)) == 16'h0000))
        else $error("port output looped into peripheral");

    a_input_only_pins: assert property ( // [RULE9]
        (pad_oe & INPUT_ONLY_MASK) == 16'h0000)
        else $error("input only pin driven");

    a_input_only_low: assert property ( // [RULE9]
        (pad_out & INPUT_ONLY_MASK) == 16'h0000)
        else $error("input only pin carries data");

    a_unimpl_no_drive: assert property ( // [RULE8]
        ((pad_oe | pad_out) & ~IMPL_MASK) == 16'h0000)
        else $error("missing pin driven");

    a_open_drain_low: assert property ( // [RULE11]
        1'b1 |=> ((pad_out & $past(st_ff.open_drain_select_reg)) == 16'h0000))
        else $error("open drain pin drove high");

    a_analog_no_feed: assert property ( // [RULE14]
        1'b1 |=> ((periph_in & $past(st_ff.analog_select_reg)) == 16'h0000))
        else $error("analog pin fed to peripheral");

    // ------------------------------------------------------------
    // assertions: register port
    // ------------------------------------------------------------
    // read data are looked at only in the one cycle they stand
    a_dir_read_back: assert property ( // [RULE4]
        (bus_req.rd && bus_req.addr == gpio_port_pkg::OFS_PIN_DIRECTION)
        |=> (bus_rdata == $past(st_ff.pin_direction_reg)))
        else $error("direction read wrong");

    a_dir_write_mask: assert property ( // [RULE8]
        (bus_req.wr && bus_req.addr == gpio_port_pkg::OFS_PIN_DIRECTION)
        |=> (st_ff.pin_direction_reg == ($past(bus_req.wdata) & IMPL_MASK)))
        else $error("direction write wrong");

    a_latch_write_load: assert property ( // [RULE6]
        (bus_req.wr && bus_req.addr == gpio_port_pkg::OFS_OUTPUT_LATCH)
        |=> (st_ff.output_latch_reg == ($past(bus_req.wdata) & IMPL_MASK)))
        else $error("latch write wrong");

    a_latch_read_back: assert property ( // [RULE6]
        (bus_req.rd && bus_req.addr == gpio_port_pkg::OFS_OUTPUT_LATCH)
        |=> (bus_rdata == $past(st_ff.output_latch_reg)))
        else $error("latch read wrong");

    a_level_read_pins: assert property ( // [RULE7]
        (bus_req.rd && bus_req.addr == gpio_port_pkg::OFS_PIN_LEVEL)
        |=> (bus_rdata == $past(level_c)))
        else $error("pin level read wrong");

    a_level_write_latch: assert property ( // [RULE7]
        (bus_req.wr && bus_req.addr == gpio_port_pkg::OFS_PIN_LEVEL)
        |=> (st_ff.output_latch_reg == ($past(bus_req.wdata) & IMPL_MASK)))
        else $error("level write missed latch");

    a_drain_write_load: assert property ( // [RULE11]
        (bus_req.wr && bus_req.addr == gpio_port_pkg::OFS_OPEN_DRAIN_SEL)
        |=> (st_ff.open_drain_select_reg == ($past(bus_req.wdata) & IMPL_MASK)))
        else $error("open drain write wrong");

    a_analog_write_mask: assert property ( // [RULE12]
        (bus_req.wr && bus_req.addr == gpio_port_pkg::OFS_ANALOG_SEL)
        |=> (st_ff.analog_select_reg == ($past(bus_req.wdata) & ANS_BITS)))
        else $error("analog select write wrong");

    a_analog_read_back: assert property ( // [RULE12]
        (bus_req.rd && bus_req.addr == gpio_port_pkg::OFS_ANALOG_SEL)
        |=> (bus_rdata == $past(st_ff.analog_select_reg)))
        else $error("analog select read wrong");

    a_unimpl_read_zero: assert property ( // [RULE8]
        bus_req.rd |=> ((bus_rdata & ~IMPL_MASK) == 16'h0000))
        else $error("unimplemented bit read nonzero");

    a_analog_read_zero: assert property ( // [RULE13]
        (bus_req.rd && bus_req.addr == gpio_port_pkg::OFS_PIN_LEVEL)
        |=> ((bus_rdata & $past(st_ff.analog_select_reg)) == 16'h0000))
        else $error("analog pin read nonzero");

    // ------------------------------------------------------------
    // cover points
    // ------------------------------------------------------------
    // the main scenarios; the bench leaves one idle cycle between strobes
    c_periph_takes_pin: cover property (own_c != 16'h0000 ##1 pad_oe != 16'h0000);
    c_level_write_read: cover property (
        (bus_req.wr && bus_req.addr == gpio_port_pkg::OFS_PIN_LEVEL)
        ##[1:2] (bus_req.rd && bus_req.addr == gpio_port_pkg::OFS_OUTPUT_LATCH));
    c_open_drain_float: cover property (
        (st_ff.open_drain_select_reg & ~st_ff.pin_direction_reg & st_ff.output_latch_reg)
        != 16'h0000);
    c_idle_periph_pin: cover property (
        (periph.enable & ~periph.drive & ~st_ff.pin_direction_reg & DRIVE_OK)
        != 16'h0000);
    c_analog_level_read: cover property (
        bus_req.rd && bus_req.addr == gpio_port_pkg::OFS_PIN_LEVEL
        && st_ff.analog_select_reg != 16'h0000);

endmodule

//--- pad_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// board pads seen from the port
// ------------------------------------------------------------
module pad_model (
    input  wire logic [15:0] pad_out,
    input  wire logic [15:0] pad_oe,
    input  wire logic [15:0] ext_level,
    output logic [15:0]      pad_in
);
    // an undriven pad settles to the board level; a floating
    // open-drain high relies on that level acting as the pull-up
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule

//--- tb.sv
`timescale 1ns/100ps
module tb;
    logic                       mclk;
    logic                       resetn;
    gpio_port_pkg::reg_req_t    bus_req;
    gpio_port_pkg::periph_out_t periph;
    logic [15:0]                bus_rdata;
    logic [15:0]                pad_in;
    logic [15:0]                pad_out;
    logic [15:0]                pad_oe;
    logic [15:0]                ext_level;
    logic [15:0]                periph_in;
    logic [15:0]                analog_mode;
    int                         fails = 0;
    int                         comparisons = 0;
    int                         cycles = 0;

    // ------------------------------------------------------------
    // design and pads
    // ------------------------------------------------------------
    // bit 15 missing and only the low byte analog, so masking shows up
    shared_parallel_io_port #(
        .IMPL_MASK       (16'h7fff),
        .ANALOG_MASK     (16'h00ff),
        .INPUT_ONLY_MASK (16'h6000)
    ) i_shared_parallel_io_port (
        .mclk(mclk), .resetn(resetn), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .periph(periph),
        .periph_in(periph_in), .analog_mode(analog_mode)
    );
    pad_model i_pad_model (
        .pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext_level), .pad_in(pad_in)
    );

    // ------------------------------------------------------------
    // clock, watchdog and helpers
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // a hang past this many cycles is a failure
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (fails == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus_req.wr <= 1'b0;
    endtask

    // read data only stand in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge mclk);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge mclk);
        bus_req.rd <= 1'b0;
        #1 chk(bus_rdata, exp);
    endtask

    // outputs move one edge later, pin reads lag two sync flops
    task automatic settle();
        repeat (4) @(posedge mclk);
        #1;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        bus_req = '0;
        periph = '0;
        ext_level = 16'hffff;
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        #1 chk(pad_oe, 16'h0000);
        rd_chk(gpio_port_pkg::OFS_PIN_DIRECTION, 16'h7fff);
        rd_chk(gpio_port_pkg::OFS_ANALOG_SEL, 16'h00ff);
        rd_chk(gpio_port_pkg::OFS_OPEN_DRAIN_SEL, 16'h0000);
        rd_chk(8'h14, 16'h0000);
        wr(gpio_port_pkg::OFS_OUTPUT_LATCH, 16'hffff);
        rd_chk(gpio_port_pkg::OFS_OUTPUT_LATCH, 16'h7fff);
        wr(gpio_port_pkg::OFS_PIN_LEVEL, 16'h00a5);
        rd_chk(gpio_port_pkg::OFS_OUTPUT_LATCH, 16'h00a5);
        // all outputs, digital: input-only pins must stay undriven
        wr(gpio_port_pkg::OFS_ANALOG_SEL, 16'h0000);
        wr(gpio_port_pkg::OFS_PIN_DIRECTION, 16'h0000);
        settle();
        chk(pad_oe, 16'h1fff);
        chk(pad_out, 16'h00a5);
        chk(periph_in, 16'h6000);
        chk(analog_mode, 16'h0000);
        rd_chk(gpio_port_pkg::OFS_PIN_LEVEL, 16'h60a5);
        // open drain: high bit floats, low bit drives
        wr(gpio_port_pkg::OFS_OPEN_DRAIN_SEL, 16'h0003);
        settle();
        chk(pad_oe, 16'h1ffe);
        chk(pad_out, 16'h00a4);
        wr(gpio_port_pkg::OFS_OPEN_DRAIN_SEL, 16'h0000);
        // peripheral owns bits 4,5; bits 6,7 enabled but idle
        @(posedge mclk);
        periph <= '{enable: 16'h00f0, drive: 16'h0030, data: 16'h0010};
        settle();
        chk(pad_out, 16'h0095);
        chk(pad_oe, 16'h1fff);
        // owned bit 4 carries the peripheral's own level back, not the port's
        chk(periph_in, 16'h6010);
        rd_chk(gpio_port_pkg::OFS_PIN_LEVEL, 16'h6095);
        // back to inputs with the low byte analog
        @(posedge mclk);
        periph <= '0;
        wr(gpio_port_pkg::OFS_PIN_DIRECTION, 16'hffff);
        wr(gpio_port_pkg::OFS_ANALOG_SEL, 16'hffff);
        settle();
        chk(pad_oe, 16'h0000);
        chk(periph_in, 16'h7f00);
        chk(analog_mode, 16'h00ff);
        rd_chk(gpio_port_pkg::OFS_PIN_LEVEL, 16'h7f00);
        // board levels change: digital bits follow them, analog bits stay zero
        @(posedge mclk);
        ext_level <= 16'h5a3c;
        settle();
        chk(periph_in, 16'h5a00);
        rd_chk(gpio_port_pkg::OFS_PIN_LEVEL, 16'h5a00);
        // second reset after making pins outputs again
        wr(gpio_port_pkg::OFS_PIN_DIRECTION, 16'h0000);
        @(posedge mclk);
        resetn <= 1'b0;
        @(posedge mclk);
        resetn <= 1'b1;
        #1 chk(pad_oe, 16'h0000);
        rd_chk(gpio_port_pkg::OFS_PIN_DIRECTION, 16'h7fff);
        rd_chk(gpio_port_pkg::OFS_OUTPUT_LATCH, 16'h0000);
        tally_and_finish();
    end
endmodule
